// File: rtl/itc_defs.svh
// Register indices, field positions and reset values of the target command block
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH

// Register byte offsets on the register port
`define ITC_IDX_CONTROL_TWO 8'h04
`define ITC_IDX_IRQ_ENABLE_CLEAR 8'h0c
`define ITC_IDX_IRQ_ENABLE_SET 8'h0d
`define ITC_IDX_EVENT_FLAGS 8'h0e
`define ITC_IDX_STATUS 8'h10
`define ITC_IDX_ADDRESS 8'h14
`define ITC_IDX_DATA 8'h18

// Fields of control_two
`define ITC_CTRL_ACK_CHOICE 18
`define ITC_CTRL_CMD_HI 17
`define ITC_CTRL_CMD_LO 16
`define ITC_CTRL_MODE_HI 15
`define ITC_CTRL_MODE_LO 14
`define ITC_CTRL_AUTO_ACK 8

// Event bits, shared by flags and enables
`define ITC_EV_BYTE_DONE 2
`define ITC_EV_ADDR_HIT 1
`define ITC_EV_STOP_SEEN 0

// Fields of status
`define ITC_ST_CLK_HOLD 7
`define ITC_ST_REP_START 4
`define ITC_ST_DIR 3
`define ITC_ST_RX_NACK 2

// Fields of the address register
`define ITC_ADDR_OWN_HI 7
`define ITC_ADDR_OWN_LO 1
`define ITC_ADDR_SECOND_HI 23
`define ITC_ADDR_SECOND_LO 17

// Reset values
`define ITC_IRQ_ENABLE_RESET 3'h0
`define ITC_FLAGS_RESET 3'h0
`define ITC_ADDR_RESET 7'h00
`define ITC_DATA_RESET 8'h00

`endif

// File: rtl/itc_link.sv
// Pin synchroniser and bus condition detector for the target command block
module itc_link
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_level_out,
	output logic scl_rise_out,
	output logic scl_fall_out,
	output logic start_out,
	output logic stop_out
);
	logic scl_s1_r; // First stage, read only by the second
	logic scl_s2_r; // Synchronised clock level
	logic scl_s3_r; // Previous synchronised level
	logic sda_s1_r; // First stage, read only by the second
	logic sda_s2_r; // Synchronised data level
	logic sda_s3_r; // Previous synchronised level

	// Two-flop synchronisers plus one history stage; lines idle high
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_s3_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_s3_r <= 1'b1;
		end
		else
		begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_s3_r <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_s3_r <= sda_s2_r;
		end
	end

	// Edges come from the synchronised stages only
	assign sda_level_out = sda_s2_r;
	assign scl_rise_out = scl_s2_r & ~scl_s3_r;
	assign scl_fall_out = ~scl_s2_r & scl_s3_r;
	// Data moving while clock stays high marks start or stop
	assign start_out = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
	assign stop_out = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
endmodule // itc_link

// File: rtl/itc_pkg.sv
// Types shared by the target command block: commands, address modes, states
package itc_pkg;
	// Command codes written to control_two
	typedef enum logic [1:0] {ITC_CMD_NOP = 2'h0, ITC_CMD_RSVD = 2'h1, ITC_CMD_DONE = 2'h2, ITC_CMD_GO = 2'h3} itc_cmd_e;
	// Address match modes
	typedef enum logic [1:0] {ITC_MODE_MASK = 2'h0, ITC_MODE_DUAL_ADDRESS = 2'h1, ITC_MODE_RANGE = 2'h2,
		ITC_MODE_RSVD = 2'h3} itc_mode_e;
	// Bus-facing sequencer states
	typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_HOLD, ST_ACK, ST_RX, ST_RX_HOLD, ST_TX, ST_TX_ACK,
		ST_TX_HOLD} itc_state_e;
	// Where the sequencer goes after an acknowledge slot
	typedef enum logic [1:0] {AFT_RX, AFT_BYTE_DONE, AFT_IDLE} itc_after_e;
endpackage

// File: rtl/itc_target.sv
// Command, address matching, smart acknowledge and interrupt enables of an I2C target
//
// Chosen here: the address-and-strobe port.
`include "itc_defs.svh"

module itc_target
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic irq_out
);
	// Register offset decode, used for every register
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
		reg_hit = (addr == idx);
	endfunction

	// Address comparison for the selected mode
	function automatic logic addr_match(input itc_pkg::itc_mode_e mode, input logic [6:0] rx,
		input logic [6:0] first, input logic [6:0] second);
		case (mode)
			itc_pkg::ITC_MODE_MASK: addr_match = (((rx ^ first) & ~second) == 7'h00);
			itc_pkg::ITC_MODE_DUAL_ADDRESS: addr_match = (rx == first) || (rx == second);
			itc_pkg::ITC_MODE_RANGE: addr_match = (rx >= second) && (rx <= first);
			default: addr_match = 1'b0; // Reserved mode never selects
		endcase
	endfunction

	// Synchronised bus conditions
	logic sda_level; // Data line level
	logic scl_rise; // Clock rising edge pulse
	logic scl_fall; // Clock falling edge pulse
	logic start_cond; // Start or repeated start pulse
	logic stop_cond; // Stop pulse

	// Software-visible state
	itc_pkg::itc_mode_e addr_match_mode_r; // Address match mode
	logic auto_ack_on_read_r; // Smart mode enable
	logic ack_choice_r; // Zero acks, one nacks
	logic [2:0] irq_enable_r; // Shared by set and clear registers
	logic [2:0] flags_r; // Sticky event flags
	logic [6:0] own_address_r; // First stored address
	logic [6:0] second_address_or_mask_r; // Second address or mask
	logic [7:0] tx_data_r; // Byte to send
	logic [7:0] rx_data_r; // Last byte received
	logic [31:0] rdata_r; // Read data register

	// Sequencer state
	itc_pkg::itc_state_e state_r; // Current step on the bus
	itc_pkg::itc_after_e after_r; // Step after the ack slot
	logic [3:0] bit_cnt_r; // Clock rises in this byte
	logic [7:0] shift_r; // Receive and send shifter
	logic sda_oe_r; // Pulling data low
	logic scl_oe_r; // Holding clock low
	logic dir_r; // Read/write bit of the last matching address
	logic rep_start_r; // Last start came while addressed
	logic rx_nack_r; // Controller nacked last sent byte
	logic selected_r; // Addressed in this transaction

	// Decoded accesses
	logic wr_ctrl; // Write to control_two
	itc_pkg::itc_cmd_e cmd; // Command code being written
	logic cmd_go; // Go command write
	logic cmd_done; // Done command write
	logic cmd_valid; // Any valid command write
	logic smart_read; // Data read with auto ack
	logic ack_now; // Ack choice seen by an action this cycle
	logic bus_quiet; // No start or stop this cycle

	// Events into the flags
	logic ev_addr_hit; // Matching address byte finished
	logic ev_byte_done; // Data byte finished or send byte wanted
	logic ev_stop; // Stop ending our transaction
	logic [2:0] flag_set; // Per-bit set
	logic [2:0] flag_clr; // Per-bit clear

	itc_link u_link
	(
		.clock_in(clock_in),
		.reset_in(reset_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_level_out(sda_level),
		.scl_rise_out(scl_rise),
		.scl_fall_out(scl_fall),
		.start_out(start_cond),
		.stop_out(stop_cond)
	);

	// Access decode
	assign wr_ctrl = reg_write_in && reg_hit(reg_addr_in, `ITC_IDX_CONTROL_TWO);
	assign cmd = itc_pkg::itc_cmd_e'(reg_wdata_in[`ITC_CTRL_CMD_HI:`ITC_CTRL_CMD_LO]);
	assign cmd_go = wr_ctrl && (cmd == itc_pkg::ITC_CMD_GO);
	assign cmd_done = wr_ctrl && (cmd == itc_pkg::ITC_CMD_DONE);
	assign cmd_valid = cmd_go || cmd_done; // Codes 0 and 1 fall out here
	assign smart_read = reg_read_in && reg_hit(reg_addr_in, `ITC_IDX_DATA) && auto_ack_on_read_r;
	// A command written with a new ack choice uses the new value
	assign ack_now = wr_ctrl ? reg_wdata_in[`ITC_CTRL_ACK_CHOICE] : ack_choice_r;
	assign bus_quiet = !start_cond && !stop_cond;

	// Events; start and stop override byte completion
	assign ev_addr_hit = bus_quiet && (state_r == itc_pkg::ST_ADDR) && scl_fall && (bit_cnt_r == 4'h8)
		&& addr_match(addr_match_mode_r, shift_r[7:1], own_address_r, second_address_or_mask_r);
	assign ev_byte_done = bus_quiet && scl_fall && (((state_r == itc_pkg::ST_RX) && (bit_cnt_r == 4'h8))
		|| (state_r == itc_pkg::ST_TX_ACK)
		|| ((state_r == itc_pkg::ST_ACK) && (after_r == itc_pkg::AFT_BYTE_DONE)));
	assign ev_stop = stop_cond && selected_r;

	// Bus sequencer: shifting, acknowledge slots and clock hold
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			state_r <= itc_pkg::ST_IDLE;
			after_r <= itc_pkg::AFT_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
			dir_r <= 1'b0;
			rep_start_r <= 1'b0;
			rx_nack_r <= 1'b0;
			selected_r <= 1'b0;
			rx_data_r <= `ITC_DATA_RESET;
		end
		else if (start_cond)
		begin
			// Any start restarts address reception and frees both lines
			rep_start_r <= selected_r;
			state_r <= itc_pkg::ST_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end
		else if (stop_cond)
		begin
			// Stop ends the transaction whatever the step
			state_r <= itc_pkg::ST_IDLE;
			selected_r <= 1'b0;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				itc_pkg::ST_ADDR, itc_pkg::ST_RX:
				begin
					// Sample on rise; the eighth fall ends the byte
					if (scl_rise)
					begin
						shift_r <= {shift_r[6:0], sda_level};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					else if (scl_fall && (bit_cnt_r == 4'h8))
					begin
						bit_cnt_r <= 4'h0;
						if (state_r == itc_pkg::ST_RX)
						begin
							rx_data_r <= shift_r;
							state_r <= itc_pkg::ST_RX_HOLD;
							scl_oe_r <= 1'b1; // Stretch until software answers
						end
						else if (ev_addr_hit)
						begin
							dir_r <= shift_r[0];
							selected_r <= 1'b1;
							state_r <= itc_pkg::ST_ADDR_HOLD;
							scl_oe_r <= 1'b1;
						end
						else
						begin
							state_r <= itc_pkg::ST_IDLE; // Not ours: wait for a start
						end
					end
				end
				itc_pkg::ST_ADDR_HOLD:
				begin
					// Go answers the address with the ack choice; a read then asks for a byte to send
					if (cmd_go)
					begin
						sda_oe_r <= !ack_now;
						after_r <= dir_r ? itc_pkg::AFT_BYTE_DONE : itc_pkg::AFT_RX;
						state_r <= itc_pkg::ST_ACK;
						scl_oe_r <= 1'b0;
					end
				end
				itc_pkg::ST_RX_HOLD:
				begin
					// Go or a smart read answers with the ack choice and continues; done answers and leaves
					if (cmd_go || smart_read)
					begin
						sda_oe_r <= !(cmd_go ? ack_now : ack_choice_r);
						after_r <= itc_pkg::AFT_RX;
						state_r <= itc_pkg::ST_ACK;
						scl_oe_r <= 1'b0;
					end
					else if (cmd_done)
					begin
						sda_oe_r <= !ack_now;
						after_r <= itc_pkg::AFT_IDLE;
						state_r <= itc_pkg::ST_ACK;
						scl_oe_r <= 1'b0;
					end
				end
				itc_pkg::ST_ACK:
				begin
					// Hold the ack bit through one clock pulse
					if (scl_fall)
					begin
						sda_oe_r <= 1'b0;
						bit_cnt_r <= 4'h0;
						case (after_r)
							itc_pkg::AFT_RX: state_r <= itc_pkg::ST_RX;
							itc_pkg::AFT_BYTE_DONE:
							begin
								state_r <= itc_pkg::ST_TX_HOLD;
								scl_oe_r <= 1'b1;
							end
							default: state_r <= itc_pkg::ST_IDLE;
						endcase
					end
				end
				itc_pkg::ST_TX_HOLD:
				begin
					// Go sends the byte; done only waits for a start
					if (cmd_go)
					begin
						shift_r <= tx_data_r;
						sda_oe_r <= !tx_data_r[7];
						bit_cnt_r <= 4'h0;
						state_r <= itc_pkg::ST_TX;
						scl_oe_r <= 1'b0;
					end
					else if (cmd_done)
					begin
						state_r <= itc_pkg::ST_IDLE; // No ack slot on a read
						scl_oe_r <= 1'b0;
					end
				end
				itc_pkg::ST_TX:
				begin
					// Next bit goes out on each fall; the eighth fall frees data
					if (scl_rise)
					begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					else if (scl_fall)
					begin
						if (bit_cnt_r == 4'h8)
						begin
							sda_oe_r <= 1'b0;
							state_r <= itc_pkg::ST_TX_ACK;
						end
						else
						begin
							sda_oe_r <= !shift_r[6];
							shift_r <= {shift_r[6:0], 1'b0};
						end
					end
				end
				itc_pkg::ST_TX_ACK:
				begin
					// Sample the controller's answer, then ask for more
					if (scl_rise)
					begin
						rx_nack_r <= sda_level;
					end
					else if (scl_fall)
					begin
						state_r <= itc_pkg::ST_TX_HOLD;
						scl_oe_r <= 1'b1;
					end
				end
				default:
				begin
					// Idle: stay off the bus until a start
					sda_oe_r <= 1'b0;
					scl_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// Configuration writes; no write synchronisation, so fields act at once
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			addr_match_mode_r <= itc_pkg::ITC_MODE_MASK;
			auto_ack_on_read_r <= 1'b0;
			ack_choice_r <= 1'b0;
			own_address_r <= `ITC_ADDR_RESET;
			second_address_or_mask_r <= `ITC_ADDR_RESET;
			tx_data_r <= `ITC_DATA_RESET;
		end
		else
		begin
			if (wr_ctrl)
			begin
				addr_match_mode_r <= itc_pkg::itc_mode_e'(reg_wdata_in[`ITC_CTRL_MODE_HI:`ITC_CTRL_MODE_LO]);
				auto_ack_on_read_r <= reg_wdata_in[`ITC_CTRL_AUTO_ACK];
				ack_choice_r <= reg_wdata_in[`ITC_CTRL_ACK_CHOICE];
			end
			if (reg_write_in && reg_hit(reg_addr_in, `ITC_IDX_ADDRESS))
			begin
				own_address_r <= reg_wdata_in[`ITC_ADDR_OWN_HI:`ITC_ADDR_OWN_LO];
				second_address_or_mask_r <= reg_wdata_in[`ITC_ADDR_SECOND_HI:`ITC_ADDR_SECOND_LO];
			end
			if (reg_write_in && reg_hit(reg_addr_in, `ITC_IDX_DATA))
			begin
				tx_data_r <= reg_wdata_in[7:0];
			end
		end
	end

	// Interrupt enables: one store behind both set and clear addresses
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			irq_enable_r <= `ITC_IRQ_ENABLE_RESET;
		end
		else if (reg_write_in && reg_hit(reg_addr_in, `ITC_IDX_IRQ_ENABLE_CLEAR))
		begin
			irq_enable_r <= irq_enable_r & ~reg_wdata_in[2:0];
		end
		else if (reg_write_in && reg_hit(reg_addr_in, `ITC_IDX_IRQ_ENABLE_SET))
		begin
			irq_enable_r <= irq_enable_r | reg_wdata_in[2:0];
		end
	end

	// Flag set and clear terms
	always_comb
	begin
		flag_set = 3'h0;
		flag_set[`ITC_EV_BYTE_DONE] = ev_byte_done;
		flag_set[`ITC_EV_ADDR_HIT] = ev_addr_hit;
		flag_set[`ITC_EV_STOP_SEEN] = ev_stop;
		// Reading the flags, or any valid command, clears all three
		flag_clr = (reg_read_in && reg_hit(reg_addr_in, `ITC_IDX_EVENT_FLAGS)) ? 3'h7 : 3'h0;
		if (cmd_valid)
		begin
			flag_clr = 3'h7;
		end
		// Writing the data byte, or a smart read of it, answers the byte event
		if (smart_read || (reg_write_in && reg_hit(reg_addr_in, `ITC_IDX_DATA)))
		begin
			flag_clr[`ITC_EV_BYTE_DONE] = 1'b1;
		end
	end

	// Sticky flags; a set in the clearing cycle wins so no event is lost
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			flags_r <= `ITC_FLAGS_RESET;
		end
		else
		begin
			flags_r <= (flags_r & ~flag_clr) | flag_set;
		end
	end

	// Registered read data, valid the cycle after the strobe
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			rdata_r <= 32'h0000_0000;
		end
		else if (reg_read_in)
		begin
			rdata_r <= 32'h0000_0000; // Unmapped addresses read zero
			if (reg_hit(reg_addr_in, `ITC_IDX_CONTROL_TWO))
			begin
				// Command field is a strobe and reads zero
				rdata_r[`ITC_CTRL_ACK_CHOICE] <= ack_choice_r;
				rdata_r[`ITC_CTRL_MODE_HI:`ITC_CTRL_MODE_LO] <= addr_match_mode_r;
				rdata_r[`ITC_CTRL_AUTO_ACK] <= auto_ack_on_read_r;
			end
			else if (reg_hit(reg_addr_in, `ITC_IDX_IRQ_ENABLE_CLEAR) || reg_hit(reg_addr_in, `ITC_IDX_IRQ_ENABLE_SET))
			begin
				rdata_r[2:0] <= irq_enable_r;
			end
			else if (reg_hit(reg_addr_in, `ITC_IDX_EVENT_FLAGS))
			begin
				rdata_r[2:0] <= flags_r;
			end
			else if (reg_hit(reg_addr_in, `ITC_IDX_STATUS))
			begin
				rdata_r[`ITC_ST_CLK_HOLD] <= scl_oe_r;
				rdata_r[`ITC_ST_REP_START] <= rep_start_r;
				rdata_r[`ITC_ST_DIR] <= dir_r;
				rdata_r[`ITC_ST_RX_NACK] <= rx_nack_r;
			end
			else if (reg_hit(reg_addr_in, `ITC_IDX_ADDRESS))
			begin
				rdata_r[`ITC_ADDR_OWN_HI:`ITC_ADDR_OWN_LO] <= own_address_r;
				rdata_r[`ITC_ADDR_SECOND_HI:`ITC_ADDR_SECOND_LO] <= second_address_or_mask_r;
			end
			else if (reg_hit(reg_addr_in, `ITC_IDX_DATA))
			begin
				rdata_r[7:0] <= rx_data_r;
			end
		end
	end

	// Outputs; open-drain lines only ever pull low
	assign reg_rdata_out = rdata_r;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_out = scl_oe_r;
	assign sda_oe_out = sda_oe_r;
	assign irq_out = |(flags_r & irq_enable_r);
endmodule // itc_target

// File: verification/itc_ctrl_model.sv
// Behavioural bus controller that clocks the target over two open-drain lines
module itc_ctrl_model
(
	input wire logic scl_line_in,
	input wire logic sda_line_in,
	output logic scl_drv_out,
	output logic sda_drv_out,
	output logic stall_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Released lines read high through the pull-ups
	initial
	begin
		scl_drv_out = 1'b1;
		sda_drv_out = 1'b1;
		stall_out = 1'b0;
	end
	// One bus clock of 64 ns; data moves mid-low, far from either edge
	task automatic bit_clock(input logic drv, output logic smp);
		int n;
		#16 sda_drv_out = drv;
		#16 scl_drv_out = 1'b1;
		n = 0;
		// Stretching is waited out, but never forever
		while (scl_line_in !== 1'b1 && n < 4000)
		begin
			#1 n++;
		end
		if (n == 4000)
			stall_out = 1'b1;
		#16 smp = sda_line_in;
		#16 scl_drv_out = 1'b0;
	endtask
	// Most significant bit goes first
	task automatic send_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_clock(b[i], s);
	endtask
	// Line released; the target shapes every bit
	task automatic recv_byte(output logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			bit_clock(1'b1, b[i]);
	endtask
	// Only called from an idle bus, else raising both lines could fake a stop
	task automatic start_cond();
		#32 sda_drv_out = 1'b0;
		#32 scl_drv_out = 1'b0;
	endtask
	task automatic stop_cond();
		#16 sda_drv_out = 1'b0;
		#16 scl_drv_out = 1'b1;
		#32 sda_drv_out = 1'b1;
		#32;
	endtask
endmodule // itc_ctrl_model

// File: verification/itc_target_properties.sv
// Port-level checker of the target command block, bound to itc_target
module itc_target_properties
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_out,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic irq_out
);
	default clocking ck @(posedge clock_in);
	endclocking
	default disable iff (reset_in);
	logic [2:0] en_r; // Shadow of the three enables
	logic [31:0] ctl_r; // Shadow of readable control fields
	logic cmd_w; // Write to control_two
	assign cmd_w = reg_write_in && reg_addr_in == 8'h04;
	// Shadows follow register writes; command bits never stored
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			en_r <= 3'h0;
			ctl_r <= 32'h0;
		end
		else if (reg_write_in && reg_addr_in == 8'h0d)
			en_r <= en_r | reg_wdata_in[2:0];
		else if (reg_write_in && reg_addr_in == 8'h0c)
			en_r <= en_r & ~reg_wdata_in[2:0];
		else if (cmd_w)
			ctl_r <= reg_wdata_in & 32'h0004_c100;
	end
	a_enable_readback: assert property (
		reg_read_in && (reg_addr_in == 8'h0c || reg_addr_in == 8'h0d) |=> reg_rdata_out == {29'h0, $past(en_r)})
		else $error("enable readback wrong");
	a_ctrl_readback: assert property (reg_read_in && reg_addr_in == 8'h04 |=> reg_rdata_out == $past(ctl_r))
		else $error("control readback wrong");
	a_irq_needs_enable: assert property (irq_out |-> en_r != 3'h0 || $past(en_r) != 3'h0)
		else $error("irq without enable");
	a_go_releases: assert property (cmd_w && reg_wdata_in[17:16] == 2'h3 && scl_oe_out |-> ##[1:2] !scl_oe_out)
		else $error("go left clock held");
	a_done_nack_quiet: assert property (cmd_w && reg_wdata_in[18:16] == 3'h6 && scl_oe_out |=> !sda_oe_out [*3])
		else $error("nack pulled data low");
	a_hold_stands: assert property (scl_oe_out && !reg_read_in && !(cmd_w && reg_wdata_in[17]) |=> scl_oe_out)
		else $error("hold dropped without command");
	a_rdata_stands: assert property (!reg_read_in |=> $stable(reg_rdata_out))
		else $error("read data moved");
	a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("pin data not low");
	c_go_held: cover property (cmd_w && reg_wdata_in[17:16] == 2'h3 && scl_oe_out);
	c_done_held: cover property (cmd_w && reg_wdata_in[17:16] == 2'h2 && scl_oe_out);
	c_irq: cover property (irq_out);
endmodule // itc_target_properties

bind itc_target itc_target_properties chk_i (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
	.reg_rdata_out(reg_rdata_out), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));

// File: verification/itc_target_tb.sv
// Self-checking bench of the target command block
module itc_target_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_in, reset_in, reg_write_in, reg_read_in, scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out;
	logic [7:0] reg_addr_in, b;
	logic [31:0] reg_wdata_in, reg_rdata_out, rd, cb;
	logic scl_drv, sda_drv, stall, s;
	wire logic scl_line = scl_drv & (scl_oe_out ? scl_out : 1'b1); // Wired-and of both parties
	wire logic sda_line = sda_drv & (sda_oe_out ? sda_out : 1'b1);
	int mismatches, compares;
	// Row: register written, value, register read, value expected
	typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] exp;} itc_row_s;
	itc_row_s rows [8] = '{'{8'h0d, 32'h5, 8'h0c, 32'h5}, '{8'h0c, 32'h1, 8'h0d, 32'h4},
		'{8'h0d, 32'h0, 8'h0d, 32'h4}, '{8'h0c, 32'hffff_fff8, 8'h0c, 32'h4},
		'{8'h04, 32'hffff_ffff, 8'h04, 32'h0004_c100}, '{8'h04, 32'h0001_4000, 8'h04, 32'h0000_4000},
		'{8'h08, 32'hffff_ffff, 8'h08, 32'h0}, '{8'h0c, 32'h7, 8'h0d, 32'h0}};
	itc_target dut (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out), .scl_in(scl_line), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));
	itc_ctrl_model ctrl (.scl_line_in(scl_line), .sda_line_in(sda_line), .scl_drv_out(scl_drv),
		.sda_drv_out(sda_drv), .stall_out(stall));
	// 200 MHz clock
	initial
	begin
		clock_in = 1'b0;
		forever
			#2.5 clock_in = ~clock_in;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		chk("controller stall", stall, 1'b0);
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask
	// Read data is taken the cycle after the strobe and stands until the next read
	task automatic rdr(input logic [7:0] a);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1 rd = reg_rdata_out;
	endtask
	// Bounded wait for the clock hold; a lost hold ends the run
	task automatic wait_hold(input logic exp);
		int n;
		n = 0;
		while (scl_oe_out !== 1'b1 && n < 40)
		begin
			@(posedge clock_in);
			#1 n++;
		end
		chk("clock hold", scl_oe_out, exp);
		if (exp && n == 40)
			test_done();
	endtask
	// Start, address byte, Go on a hit, then the acknowledge slot
	task automatic addr_phase(input logic [7:0] ab, input logic hit);
		ctrl.start_cond();
		ctrl.send_byte(ab);
		wait_hold(hit);
		if (hit)
		begin
			chk("irq on hit", irq_out, 1'b1);
			wr(8'h04, cb | 32'h0001_0000);
			rdr(8'h10);
			chk("hold after reserved code", rd[7], 1'b1);
			chk("direction", rd[3], ab[0]);
			wr(8'h04, cb | 32'h0003_0000);
			rdr(8'h0e);
			chk("flags after go", rd, 32'h0);
		end
		ctrl.bit_clock(1'b1, s);
		chk("address ack", s, !hit);
	endtask
	task automatic addr_try(input logic [7:0] ab, input logic hit);
		addr_phase(ab, hit);
		ctrl.stop_cond();
		rdr(8'h0e);
		chk("stop flag", rd, {31'h0, hit});
	endtask
	// Watchdog
	initial
	begin
		#200000;
		mismatches++;
		test_done();
	end
	initial
	begin
		reset_in = 1'b1;
		reg_addr_in = 8'h0;
		reg_wdata_in = 32'h0;
		reg_write_in = 1'b0;
		reg_read_in = 1'b0;
		cb = 32'h0;
		repeat (4) @(posedge clock_in);
		reset_in <= 1'b0;
		rdr(8'h0c);
		chk("enables at reset", rd, 32'h0);
		rdr(8'h04);
		chk("control at reset", rd, 32'h0);
		chk("irq at reset", irq_out, 1'b0);
		$display("test reset done");
		foreach (rows[i])
		begin
			wr(rows[i].wa, rows[i].wd);
			rdr(rows[i].ra);
			chk("register row", rd, rows[i].exp);
		end
		$display("test registers done");
		// Address matching in every mode, own address 0x2a, then 0x30 from the range mode on
		wr(8'h0d, 32'h7);
		wr(8'h04, cb);
		wr(8'h14, 32'h0002_0054);
		addr_try(8'h56, 1'b1);
		addr_try(8'h58, 1'b0);
		cb = 32'h0000_4000;
		wr(8'h04, cb);
		wr(8'h14, 32'h0022_0054);
		addr_try(8'h22, 1'b1);
		addr_try(8'h54, 1'b1);
		addr_try(8'h56, 1'b0);
		cb = 32'h0000_8000;
		wr(8'h04, cb);
		wr(8'h14, 32'h0040_0060);
		addr_try(8'h40, 1'b1);
		addr_try(8'h60, 1'b1);
		addr_try(8'h62, 1'b0);
		addr_try(8'h3e, 1'b0);
		cb = 32'h0000_c000;
		wr(8'h04, cb);
		addr_try(8'h60, 1'b0);
		$display("test matching done");
		// Controller write: Go, smart read, then Done with NACK
		cb = 32'h0;
		wr(8'h04, cb);
		wr(8'h14, 32'h0002_0054);
		addr_phase(8'h54, 1'b1);
		ctrl.send_byte(8'h5a);
		wait_hold(1'b1);
		rdr(8'h18);
		chk("rx byte", rd, 32'h5a);
		wr(8'h04, 32'h0003_0000);
		ctrl.bit_clock(1'b1, s);
		chk("go ack", s, 1'b0);
		wr(8'h04, 32'h0000_0100);
		ctrl.send_byte(8'h3c);
		wait_hold(1'b1);
		rdr(8'h18);
		chk("smart byte", rd, 32'h3c);
		ctrl.bit_clock(1'b1, s);
		chk("smart ack", s, 1'b0);
		ctrl.send_byte(8'h96);
		wait_hold(1'b1);
		wr(8'h04, 32'h0006_0100);
		ctrl.bit_clock(1'b1, s);
		chk("done nack", s, 1'b1);
		ctrl.send_byte(8'hff);
		wait_hold(1'b0);
		ctrl.bit_clock(1'b1, s);
		wr(8'h0c, 32'h1);
		ctrl.stop_cond();
		rdr(8'h0d);
		chk("enables", rd, 32'h6);
		chk("masked irq", irq_out, 1'b0);
		wr(8'h0d, 32'h1);
		rdr(8'h0c);
		chk("unmasked irq", irq_out, 1'b1);
		rdr(8'h0e);
		chk("stop flag", rd, 32'h1);
		chk("irq after flag read", irq_out, 1'b0);
		$display("test write done");
		// Controller read: Go twice, NACK from controller, then Done
		addr_phase(8'h55, 1'b1);
		wait_hold(1'b1);
		rdr(8'h0e);
		chk("ready after go", rd, 32'h4);
		wr(8'h18, 32'hc3);
		wr(8'h04, 32'h0003_0000);
		ctrl.recv_byte(b);
		chk("tx byte", b, 8'hc3);
		ctrl.bit_clock(1'b1, s);
		wait_hold(1'b1);
		rdr(8'h10);
		chk("rx nack", rd[2], 1'b1);
		wr(8'h04, 32'h0002_0000);
		ctrl.recv_byte(b);
		chk("idle after done", b, 8'hff);
		ctrl.stop_cond();
		$display("test read done");
		test_done();
	end
endmodule // itc_target_tb
